/* rtl/tag_dma_frame_assembler.sv */
// Tag frame DMA, transmit frame assembler and receive byte writer with AHB-Lite registers
`timescale 1ns/1ps
`include "tag_dma_regs.svh"
module tag_dma_frame_assembler
	import tag_dma_pkg::*;
(
	// Clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [11:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Pin protection strap from the user configuration area
	input  wire logic               antenna_pin_config,
	output logic                    pin_protect_en,
	output logic                    pin_gpio_en,
	// RAM port
	output tag_dma_pkg::ram_req_s   ram_req,
	input  wire logic [7:0]         ram_rdata,
	input  wire logic               ram_ack,
	// Front end
	output tag_dma_pkg::tx_sym_s    tx_sym,
	input  wire logic               tx_sym_ready,
	input  wire tag_dma_pkg::rx_byte_s rx_in
);
	import tag_dma_pkg::*;

	// ==========================================================
	// Strap capture
	logic        strap_meta_q;
	logic        strap_sync_q;
	logic [1:0]  rst_cnt_q;
	logic        protect_q;
	// Strap passes two flops; it is taken a few cycles after release
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
		end
		else
		begin
			strap_meta_q <= antenna_pin_config;
			strap_sync_q <= strap_meta_q;
		end
	end
	// Reload at every reset release
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rst_cnt_q <= 2'h0;
			protect_q <= 1'b0;
		end
		else if (rst_cnt_q != 2'h3)
		begin
			rst_cnt_q <= rst_cnt_q + 2'h1;
			if (rst_cnt_q == 2'h2)
				protect_q <= strap_sync_q == `PROTECT_TAG;
		end
	end
	assign pin_protect_en = protect_q;
	assign pin_gpio_en    = !protect_q;

	// ==========================================================
	// Registers
	logic        ph_wr_q;
	logic        ph_rd_q;
	logic [11:0] ph_addr_q;
	logic [31:0] bufptr_q;
	logic [8:0]  buflim_q;
	logic [5:0]  txcfg_q;
	logic [11:0] txlen_q;
	logic [5:0]  rxcfg_q;
	logic [11:0] rxlen_q;
	logic        overflow_q;
	logic [5:0]  evt_q;
	logic [5:0]  evt_set;
	logic        task_tx;
	logic        task_rx;
	logic        wr_evt;
	dma_state_e  state_q;
	logic        aphase;

	assign aphase    = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_wr_q   <= 1'b0;
			ph_rd_q   <= 1'b0;
			ph_addr_q <= 12'h000;
		end
		else
		begin
			ph_wr_q   <= aphase && hwrite;
			ph_rd_q   <= aphase && !hwrite;
			ph_addr_q <= haddr;
		end
	end
	assign task_tx = ph_wr_q && ph_addr_q == `OFS_TASKS && hwdata[`TASK_TX_START];
	assign task_rx = ph_wr_q && ph_addr_q == `OFS_TASKS && hwdata[`TASK_RX_ARM];
	assign wr_evt  = ph_wr_q && ph_addr_q == `OFS_EVENTS;
	// Configuration writes; the block trusts software not to touch them mid-frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bufptr_q <= 32'h0000_0000;
			buflim_q <= `BUFLIM_RST;
			txcfg_q  <= 6'h00;
			txlen_q  <= 12'h000;
			rxcfg_q  <= 6'h00;
		end
		else if (ph_wr_q)
		begin
			unique case (ph_addr_q)
				`OFS_BUFPTR: bufptr_q <= hwdata;
				`OFS_BUFLIM: buflim_q <= hwdata[8:0];
				`OFS_TXCFG:  txcfg_q  <= hwdata[5:0];
				`OFS_TXLEN:  txlen_q  <= hwdata[11:0];
				`OFS_RXCFG:  rxcfg_q  <= hwdata[5:0];
				default:     ;
			endcase
		end
	end
	// Sticky events, write one to clear; a new set wins over the clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			evt_q <= 6'h00;
		else
			evt_q <= (evt_q & ~(wr_evt ? hwdata[5:0] : 6'h00)) | evt_set;
	end
	// Read mux, one cycle after the address phase
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (ph_rd_q)
		begin
			unique case (ph_addr_q)
				`OFS_EVENTS: hrdata = {26'h0, evt_q};
				`OFS_BUFPTR: hrdata = bufptr_q;
				`OFS_BUFLIM: hrdata = {23'h0, buflim_q};
				`OFS_TXCFG:  hrdata = {26'h0, txcfg_q};
				`OFS_TXLEN:  hrdata = {20'h0, txlen_q};
				`OFS_RXCFG:  hrdata = {26'h0, rxcfg_q};
				`OFS_RXLEN:  hrdata = {20'h0, rxlen_q};
				`OFS_RXSTAT: hrdata = {31'h0, overflow_q};
				`OFS_STATE:  hrdata = {28'h0, protect_q, state_q};
				default:     hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// DMA engine
	logic [31:0] ptr_q;
	logic [8:0]  lim_q;
	logic [8:0]  fetch_q;
	logic [8:0]  idx_q;
	logic [7:0]  shreg_q;
	logic [3:0]  bit_q;
	logic [3:0]  nbits_q;
	logic        par_q;
	logic        need_par_q;
	logic [15:0] crc_q;
	logic [4:0]  crcbit_q;
	logic        armed_q;
	logic        rd_pend_q;
	logic        sof_q;
	logic        rx_act_q;
	logic [8:0]  rx_cnt_q;
	logic [8:0]  total_bytes;
	logic [2:0]  xbits;
	logic        crc_fb;
	logic        sym_take;

	assign xbits       = txlen_q[2:0];
	// Whole bytes plus one when extra bits are asked
	assign total_bytes = txlen_q[11:3] + {8'h00, xbits != 3'h0};
	assign sym_take    = tx_sym.bit_valid && tx_sym_ready;
	assign crc_fb      = crc_q[0] ^ shreg_q[0];
	// Only one direction reaches RAM at a time
	assign ram_req.req   = rd_pend_q || (state_q == ST_RX && rx_in.valid && rx_act_q
				&& rx_cnt_q < lim_q);
	assign ram_req.we    = state_q == ST_RX;
	assign ram_req.addr  = ptr_q + {23'h0, state_q == ST_RX ? rx_cnt_q : idx_q};
	assign ram_req.wdata = rx_in.data;
	assign tx_sym.sof    = sof_q;
	// End of frame follows the last payload or CRC bit, with or without CRC
	assign tx_sym.eof    = state_q == ST_TXCRC && crcbit_q == 5'h00;
	assign tx_sym.bit_val = (state_q == ST_TXCRC) ? crc_q[0] :
				(need_par_q ? ~par_q : shreg_q[0]);
	// Valid drops once the byte and its parity are out, so no bit goes twice
	assign tx_sym.bit_valid = (state_q == ST_TXBITS && (bit_q != nbits_q || need_par_q)) ||
				(state_q == ST_TXCRC && crcbit_q != 5'h00);

	// Frame state machine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q    <= ST_OFF;
			ptr_q      <= 32'h0000_0000;
			lim_q      <= 9'h000;
			fetch_q    <= 9'h000;
			idx_q      <= 9'h000;
			shreg_q    <= 8'h00;
			bit_q      <= 4'h0;
			nbits_q    <= 4'h0;
			par_q      <= 1'b0;
			need_par_q <= 1'b0;
			crc_q      <= `CRC_INIT;
			crcbit_q   <= 5'h00;
			armed_q    <= 1'b0;
			rd_pend_q  <= 1'b0;
			sof_q      <= 1'b0;
			rx_act_q   <= 1'b0;
			rx_cnt_q   <= 9'h000;
			rxlen_q    <= 12'h000;
			overflow_q <= 1'b0;
			evt_set    <= 6'h00;
		end
		else
		begin
			evt_set <= 6'h00;
			unique case (state_q)
				ST_OFF:
					// Held here while protection is off
					if (rst_cnt_q == 2'h3 && protect_q)
						state_q <= ST_IDLE;
				ST_IDLE:
					if (task_tx)
					begin
						// Transmit beats receive arm latch per frame
						ptr_q   <= bufptr_q;
						lim_q   <= buflim_q;
						fetch_q <= (total_bytes > buflim_q) ? buflim_q : total_bytes;
						idx_q   <= 9'h000;
						crc_q   <= `CRC_INIT;
						sof_q   <= txcfg_q[`CFG_SOF];
						evt_set[`EVT_CAPTURED] <= 1'b1;
						evt_set[`EVT_TXSTART]  <= 1'b1;
						rd_pend_q <= total_bytes != 9'h000 && buflim_q != 9'h000;
						state_q   <= ST_TXFETCH;
					end
					else if (task_rx)
					begin
						ptr_q      <= bufptr_q;
						lim_q      <= buflim_q;
						armed_q    <= 1'b1;
						rx_cnt_q   <= 9'h000;
						rx_act_q   <= 1'b0;
						overflow_q <= 1'b0;
						evt_set[`EVT_CAPTURED] <= 1'b1;
						state_q    <= ST_RX;
					end
				ST_TXFETCH:
					if (fetch_q == 9'h000)
					begin
						evt_set[`EVT_TXEND] <= 1'b1;
						crcbit_q <= txcfg_q[`CFG_CRC] ? 5'h10 : 5'h00;
						state_q  <= ST_TXCRC;
					end
					else if (ram_ack)
					begin
						rd_pend_q  <= 1'b0;
						par_q      <= 1'b0;
						need_par_q <= 1'b0;
						bit_q      <= 4'h0;
						// Trim leading or trailing bits of the short byte
						if (xbits != 3'h0 && txcfg_q[`CFG_TRIM] && idx_q == 9'h000)
						begin
							shreg_q <= ram_rdata >> (4'h8 - {1'b0, xbits});
							nbits_q <= {1'b0, xbits};
						end
						else if (xbits != 3'h0 && !txcfg_q[`CFG_TRIM]
							&& idx_q == total_bytes - 9'h001)
						begin
							shreg_q <= ram_rdata;
							nbits_q <= {1'b0, xbits};
						end
						else
						begin
							shreg_q <= ram_rdata;
							nbits_q <= 4'h8;
						end
						// Last byte to be fetched, within the buffer limit, has been read
						if (fetch_q == 9'h001)
							evt_set[`EVT_TXEND] <= 1'b1;
						state_q <= ST_TXBITS;
					end
				ST_TXBITS:
					if (sym_take)
					begin
						sof_q <= 1'b0;
						if (need_par_q)
						begin
							need_par_q <= 1'b0;
							bit_q      <= nbits_q;
						end
						else
						begin
							// Payload bits only; CRC over every payload bit sent, short byte included
							par_q   <= par_q ^ shreg_q[0];
							shreg_q <= {1'b0, shreg_q[7:1]};
							crc_q   <= crc_fb ? ((crc_q >> 1) ^ `CRC_POLY) : (crc_q >> 1);
							bit_q   <= bit_q + 4'h1;
							// Parity after full bytes or a trimmed first byte
							if (bit_q + 4'h1 == nbits_q && txcfg_q[`CFG_PARITY]
								&& (nbits_q == 4'h8 || txcfg_q[`CFG_TRIM]))
								need_par_q <= 1'b1;
						end
					end
					else if (bit_q == nbits_q && !need_par_q)
					begin
						idx_q   <= idx_q + 9'h001;
						fetch_q <= fetch_q - 9'h001;
						rd_pend_q <= fetch_q != 9'h001;
						state_q <= ST_TXFETCH;
					end
				ST_TXCRC:
					if (crcbit_q == 5'h00)
						state_q <= ST_IDLE;
					else if (sym_take)
					begin
						crc_q    <= crc_q >> 1;
						crcbit_q <= crcbit_q - 5'h01;
					end
				ST_RX:
				begin
					if (rx_in.sof && armed_q)
					begin
						rx_act_q <= 1'b1;
						armed_q  <= 1'b0;
						evt_set[`EVT_RXSTART] <= 1'b1;
					end
					if (rx_in.valid && rx_act_q)
					begin
						// Store and count up to the limit; further bytes only set overflow
						if (rx_cnt_q < lim_q)
							rx_cnt_q <= rx_cnt_q + 9'h001;
						else
							overflow_q <= 1'b1;
					end
					if (rx_in.eof && rx_act_q)
					begin
						rx_act_q <= 1'b0;
						rxlen_q  <= {rx_cnt_q, 3'h0};
						evt_set[`EVT_RXEND] <= 1'b1;
						evt_set[`EVT_RXERR] <= overflow_q;
						state_q  <= ST_IDLE;
					end
				end
				default:
					state_q <= ST_OFF;
			endcase
		end
	end

	// ==========================================================
	// Checks
	property p_off_stays;
		@(posedge hclk) disable iff (!hresetn)
		(rst_cnt_q == 2'h3 && !protect_q) |-> state_q == ST_OFF;
	endproperty
	a_off_stays: assert property (p_off_stays) else $error("left off state");
	property p_one_dir;
		@(posedge hclk) disable iff (!hresetn)
		ram_req.req |-> (ram_req.we ? (state_q == ST_RX && !rd_pend_q)
			: state_q == ST_TXFETCH);
	endproperty
	a_one_dir: assert property (p_one_dir) else $error("write outside receive");
	property p_tx_prio;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_IDLE && task_tx && task_rx) |=> state_q == ST_TXFETCH;
	endproperty
	a_tx_prio: assert property (p_tx_prio) else $error("receive beat transmit");
	property p_captured;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_IDLE && (task_tx || task_rx)) |=> ##1 evt_q[`EVT_CAPTURED];
	endproperty
	a_captured: assert property (p_captured) else $error("no captured event");
	property p_limit;
		@(posedge hclk) disable iff (!hresetn)
		ram_req.req |-> (ram_req.we ? rx_cnt_q : idx_q) < lim_q;
	endproperty
	a_limit: assert property (p_limit) else $error("access past limit");
	property p_overflow;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_RX && rx_in.eof && rx_act_q && overflow_q) |=> ##1 evt_q[`EVT_RXERR];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not reported");
	property p_rxend;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_RX && rx_in.eof && rx_act_q) |=>
			(rxlen_q == {$past(rx_cnt_q), 3'h0}) ##1 evt_q[`EVT_RXEND];
	endproperty
	a_rxend: assert property (p_rxend) else $error("receive end wrong");
	property p_pins;
		@(posedge hclk) disable iff (!hresetn)
		(state_q != ST_OFF) |-> (pin_protect_en && !pin_gpio_en);
	endproperty
	a_pins: assert property (p_pins) else $error("operating without pin protection");
	property p_txstart;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_IDLE && task_tx) |=> ##1 evt_q[`EVT_TXSTART];
	endproperty
	a_txstart: assert property (p_txstart) else $error("no transmit start");
endmodule

/* rtl/tag_dma_regs.svh */
// Register offsets, field positions, reset values and limits of the tag frame DMA
`ifndef TAG_DMA_REGS_SVH
`define TAG_DMA_REGS_SVH
`define OFS_TASKS        12'h000
`define OFS_EVENTS       12'h004
`define OFS_BUFPTR       12'h008
`define OFS_BUFLIM       12'h00c
`define OFS_TXCFG        12'h010
`define OFS_TXLEN        12'h014
`define OFS_RXCFG        12'h018
`define OFS_RXLEN        12'h01c
`define OFS_RXSTAT       12'h020
`define OFS_STATE        12'h024
`define OFS_RXDATA       12'h028
`define TASK_TX_START    0
`define TASK_RX_ARM      1
`define EVT_CAPTURED     0
`define EVT_TXSTART      1
`define EVT_TXEND        2
`define EVT_RXSTART      3
`define EVT_RXEND        4
`define EVT_RXERR        5
`define CFG_PARITY       0
`define CFG_TRIM         1
`define CFG_SOF          2
`define CFG_CRC          4
`define PROTECT_TAG      1'b1
`define BUFLIM_RST       9'h000
`define CRC_INIT         16'h6363
`define CRC_POLY         16'h8408
`endif

/* rtl/tag_dma_pkg.sv */
// Types shared by the tag frame DMA and assembler
package tag_dma_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_TXFETCH, ST_TXBITS, ST_TXCRC, ST_RX}
		dma_state_e;
	typedef struct packed {
		logic [31:0] addr;
		logic        we;
		logic [7:0]  wdata;
		logic        req;
	} ram_req_s;
	typedef struct packed {
		logic bit_val;
		logic bit_valid;
		logic sof;
		logic eof;
	} tx_sym_s;
	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       sof;
		logic       eof;
	} rx_byte_s;
endpackage

/* dv/tag_reader.sv */
// RAM and reader model on the far side of the tag frame DMA
`timescale 1ns/1ps
module tag_reader
	import tag_dma_pkg::*;
(
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// RAM side
	input  wire tag_dma_pkg::ram_req_s ram_req,
	output logic      [7:0]            ram_rdata,
	output logic                       ram_ack,
	// Field side
	input  wire tag_dma_pkg::tx_sym_s  tx_sym,
	output logic                       tx_sym_ready,
	output tag_dma_pkg::rx_byte_s      rx_in
);
	import tag_dma_pkg::*;

	logic [7:0] mem [256];
	logic       bits [$];
	int         rd_cnt = 0;
	int         sof_cnt = 0;
	int         eof_cnt = 0;
	int         seed = 91;

	initial rx_in = '0;

	// ==========================================================
	// RAM: reads answered after a random stall, writes stored at once
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ram_ack <= 1'b0;
			ram_rdata <= 8'h00;
		end
		else
		begin
			ram_ack <= 1'b0;
			ram_rdata <= ~ram_rdata; // Released data never keeps its last value
			if (ram_req.req && !ram_req.we && !ram_ack && $random(seed) % 2 == 0)
			begin
				ram_ack <= 1'b1;
				ram_rdata <= mem[ram_req.addr[7:0]];
				rd_cnt++;
			end
			if (ram_req.req && ram_req.we)
				mem[ram_req.addr[7:0]] <= ram_req.wdata;
		end
	end

	// ==========================================================
	// Field: symbols taken at a random pace so the assembler must stall
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tx_sym_ready <= 1'b0;
		else
		begin
			tx_sym_ready <= ($random(seed) % 3) != 0;
			if (tx_sym.bit_valid && tx_sym_ready)
			begin
				bits.push_back(tx_sym.bit_val);
				if (tx_sym.sof)
					sof_cnt++;
			end
			if (tx_sym.eof)
				eof_cnt++;
		end
	end

	// Reader frame: start pulse, n bytes counting up from b0, end pulse
	task automatic send_rx(input int n, input logic [7:0] b0);
		for (int i = -1; i <= n; i++)
		begin
			@(posedge hclk);
			rx_in <= '{data: b0 + 8'(i), valid: (i >= 0 && i < n), sof: (i < 0), eof: (i == n)};
			@(posedge hclk);
			rx_in <= '{data: ~(b0 + 8'(i)), valid: 1'b0, sof: 1'b0, eof: 1'b0};
		end
	endtask
endmodule

/* dv/test_tag_dma_frame_assembler.sv */
// Self-checking bench for the tag frame DMA and assembler
`timescale 1ns/1ps
`include "tag_dma_regs.svh"
module test_tag_dma_frame_assembler;
	import tag_dma_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        antenna_pin_config, pin_protect_en, pin_gpio_en, ram_ack, tx_sym_ready;
	logic [7:0]  ram_rdata;
	ram_req_s    ram_req;
	tx_sym_s     tx_sym;
	rx_byte_s    rx_in;
	logic        exp_q [$];
	logic [4:0]  cfg_tab [6] = '{5'h00, 5'h01, 5'h03, 5'h01, 5'h15, 5'h00};
	int          nb_tab [6] = '{2, 3, 2, 2, 1, 4};
	int          xb_tab [6] = '{0, 0, 3, 5, 0, 0};
	int          lim_tab [6] = '{2, 3, 3, 3, 1, 2};
	int          err_count = 0;
	int          n_tests = 0;
	int          seed = 91;
	int          rd0, sof0, eof0, nf, w, n;

	tag_dma_frame_assembler u_tag_dma_frame_assembler (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .antenna_pin_config(antenna_pin_config),
		.pin_protect_en(pin_protect_en), .pin_gpio_en(pin_gpio_en), .ram_req(ram_req),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .tx_sym(tx_sym),
		.tx_sym_ready(tx_sym_ready), .rx_in(rx_in));
	tag_reader u_tag_reader (.hclk(hclk), .hresetn(hresetn), .ram_req(ram_req),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .tx_sym(tx_sym),
		.tx_sym_ready(tx_sym_ready), .rx_in(rx_in));

	// ==========================================================
	// Clock
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One single AHB-Lite word transfer; the wait is bounded, not assumed
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		hsize <= 3'h2;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
		rd = hrdata;
		if (k >= 100)
		begin
			err_count++;
			complete_run();
		end
	endtask

	// Reference bit stream of one transmit frame: payload, parity, CRC when enabled
	task automatic build(input logic [4:0] c, input int nb, input int xb);
		int lo, hi;
		logic p;
		logic pb;
		logic [15:0] crc;
		exp_q.delete();
		crc = `CRC_INIT;
		for (int i = 0; i < nb + (xb > 0); i++)
		begin
			lo = (xb > 0 && c[`CFG_TRIM] && i == 0) ? 8 - xb : 0;
			hi = (xb > 0 && !c[`CFG_TRIM] && i == nb) ? xb : 8;
			p = 1'b1;
			for (int b = lo; b < hi; b++)
			begin
				pb = u_tag_reader.mem[8'h10 + i][b];
				exp_q.push_back(pb);
				p ^= pb;
				// CRC runs over payload bits only, never over parity
				crc = (crc[0] ^ pb) ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
			end
			if (c[`CFG_PARITY] && hi == 8)
				exp_q.push_back(p);
		end
		if (c[`CFG_CRC])
			for (int b = 0; b < 16; b++)
				exp_q.push_back(crc[b]);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		antenna_pin_config = 1'b1;
		hresetn = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(32'({pin_protect_en, pin_gpio_en}), 32'h2);
		bus(1'b0, `OFS_STATE, 32'h0);
		chk(rd, 32'({1'b1, ST_IDLE}));
		bus(1'b1, 12'h03c, 32'hffffffff);
		bus(1'b0, 12'h03c, 32'h0);
		chk(rd, 32'h0);
		// Transmit frames over the framing table
		for (int i = 0; i < 6; i++)
		begin
			for (int j = 0; j < 8; j++)
				u_tag_reader.mem[8'h10 + j] = 8'($random(seed));
			u_tag_reader.bits.delete();
			rd0 = u_tag_reader.rd_cnt;
			sof0 = u_tag_reader.sof_cnt;
			eof0 = u_tag_reader.eof_cnt;
			nf = nb_tab[i] + (xb_tab[i] > 0);
			bus(1'b1, `OFS_EVENTS, 32'h3f);
			bus(1'b1, `OFS_BUFPTR, 32'h10);
			bus(1'b1, `OFS_BUFLIM, 32'(lim_tab[i]));
			bus(1'b1, `OFS_TXCFG, 32'(cfg_tab[i]));
			bus(1'b1, `OFS_TXLEN, 32'(nb_tab[i] * 8 + xb_tab[i]));
			bus(1'b1, `OFS_TASKS, (i == 5) ? 32'h3 : 32'h1);
			for (w = 0; w < 3000 && u_tag_reader.eof_cnt == eof0; w++)
				@(posedge hclk);
			if (w == 3000)
			begin
				err_count++;
				complete_run();
			end
			build(cfg_tab[i], nb_tab[i], xb_tab[i]);
			chk(32'(u_tag_reader.rd_cnt - rd0), 32'((nf < lim_tab[i]) ? nf : lim_tab[i]));
			bus(1'b0, `OFS_EVENTS, 32'h0);
			chk(rd, 32'h07);
			if (lim_tab[i] >= nf)
			begin
				chk(32'(u_tag_reader.bits.size()), 32'(exp_q.size()));
				for (int k = 0; k < exp_q.size(); k++)
					chk(32'(u_tag_reader.bits[k]), 32'(exp_q[k]));
				chk(32'(u_tag_reader.sof_cnt - sof0), 32'(cfg_tab[i][`CFG_SOF]));
			end
		end
		// Receive frames, one within the limit and one overlong
		for (int i = 0; i < 2; i++)
		begin
			n = i ? 5 : 2;
			for (int j = 0; j < 6; j++)
				u_tag_reader.mem[8'h40 + j] = 8'h5a;
			bus(1'b1, `OFS_EVENTS, 32'h3f);
			bus(1'b1, `OFS_BUFPTR, 32'h40);
			bus(1'b1, `OFS_BUFLIM, 32'h3);
			bus(1'b1, `OFS_TASKS, 32'h2);
			bus(1'b1, `OFS_BUFPTR, 32'h80);
			u_tag_reader.send_rx(n, 8'ha0);
			for (w = 0; w < 50 && rd[`EVT_RXEND] !== 1'b1; w++)
				bus(1'b0, `OFS_EVENTS, 32'h0);
			if (rd[`EVT_RXEND] !== 1'b1)
			begin
				err_count++;
				complete_run();
			end
			chk(rd, (n > 3) ? 32'h39 : 32'h19);
			for (int j = 0; j < 6; j++)
				chk(32'(u_tag_reader.mem[8'h40 + j]), (j < 3 && j < n) ? 32'(8'ha0 + j) : 32'h5a);
			bus(1'b0, `OFS_RXSTAT, 32'h0);
			chk(rd, 32'(n > 3));
			bus(1'b0, `OFS_RXLEN, 32'h0);
			if (n < 3)
				chk(rd, 32'(n << 3));
		end
		// Second reset with protection off: pins released, block stays off
		hresetn <= 1'b0;
		antenna_pin_config <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(32'({pin_protect_en, pin_gpio_en}), 32'h1);
		rd0 = u_tag_reader.rd_cnt;
		bus(1'b1, `OFS_TASKS, 32'h1);
		repeat (20) @(posedge hclk);
		bus(1'b0, `OFS_STATE, 32'h0);
		chk(rd, 32'({1'b0, ST_OFF}));
		chk(32'(u_tag_reader.rd_cnt - rd0), 32'h0);
		complete_run();
	end
endmodule
